// ### rtl/wdsc_map.svh
`ifndef WDSC_MAP_SVH
`define WDSC_MAP_SVH
// Overview of operation
// - Watchdog counts ticks of its own RC oscillator, alive in power-down.
// - Time-out while running requests a full device reset.
// - Time-out in power-down wakes the core without reset.
// - Watchdog stays disabled while the config enable bit is zero.
// - Base time-out period is 18 ms without prescaler.
// - Software assigns the prescaler to the watchdog, up to 1:128.
// - Kick and sleep instructions clear counter and assigned prescaler.
// - Every time-out clears the timeout flag.
// - Sleep clears watchdog, clears powerdown flag, sets timeout flag, stops osc, holds I/O.
// - Watchdog reset never drives the master-clear pin low.
// - Wake on master-clear, time-out or enabled interrupt; only master-clear resets.
// - Powerdown flag set at power-up, cleared by sleep.
// - Interrupt wakes only if its own enable is set, ignoring global enable.
// - After interrupt wake run next instruction, then vector 0004h if enabled.
// - Next instruction is prefetched while sleep executes.
// - Pending enabled interrupt at sleep completes sleep and wakes at once.
// - Watchdog counter cleared on every wake-up.
// - Crystal modes wait 1024 oscillator periods after time-out or interrupt wake-up; master-clear wake skips the wait.
// - Global interrupt enable cleared on every reset.

// ======================================================
// Register map
`define WDSC_ADDR_W          14
`define WDSC_STATUS_ADDR     14'h0003
`define WDSC_IRQCTL_ADDR     14'h000B
`define WDSC_PRESCALE_ADDR   14'h0081
`define WDSC_CONFIG_ADDR     14'h2007
`define WDSC_PRESCALE_RST    8'hFF

// ======================================================
// Field positions
`define WDSC_STAT_TO_BIT     4
`define WDSC_STAT_PD_BIT     3
`define WDSC_GIE_BIT         7
`define WDSC_PSA_BIT         3
`define WDSC_PS_MSB          2
`define WDSC_CFG_WATCHDOG_FUSE_ENABLE_BIT    3
`define WDSC_CFG_FOSC_MSB    2
`define WDSC_FOSC_LAST_XTAL  3'h2
`define WDSC_IRQ_VECTOR      13'h0004

// ======================================================
// Timing
`define WDSC_BASE_PERIOD_US  18000
`define WDSC_RC_TICK_NS      1000
`define WDSC_CLK_NS          25
`define WDSC_OST_TOSC        1024
`endif

// ### rtl/wdsc_pkg.sv
package wdsc_pkg;

  typedef enum logic [2:0] {
    WDSC_RUN   = 3'b001,
    WDSC_SLEEP = 3'b010,
    WDSC_OST   = 3'b100
  } wdsc_state_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [13:0] addr;
    logic [7:0]  wdata;
  } wdsc_bus_req_t;

  typedef struct packed {
    logic kick;
    logic sleep;
  } wdsc_instr_t;

endpackage

// ### rtl/wdsc_top.sv
`timescale 1ns/10ps
`include "wdsc_map.svh"

module wdsc_top #(
  parameter int NUM_IRQ     = 7,
  parameter int RC_TICK_NS  = `WDSC_RC_TICK_NS,
  parameter int BASE_TICKS  = (`WDSC_BASE_PERIOD_US * 1000) / RC_TICK_NS,
  parameter int OST_CYCLES  = `WDSC_OST_TOSC
) (
  // Clock and power-up reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // Register port
  input  wire wdsc_pkg::wdsc_bus_req_t bus_req,
  output logic [7:0]                 bus_rdata,
  // Non-volatile configuration word
  input  wire logic [7:0]            config_word,
  // Free-running RC oscillator tick
  input  wire logic                  rc_osc_tick,
  // Core instruction events
  input  wire wdsc_pkg::wdsc_instr_t instr,
  // Interrupt sources
  input  wire logic [NUM_IRQ-1:0]    irq_enable_vec,
  input  wire logic [NUM_IRQ-1:0]    irq_flag_vec,
  // Master-clear pin, open drain
  input  wire logic                  master_clear_pin_in,
  output logic                       master_clear_pin_out,
  output logic                       master_clear_pin_oe,
  // Core control
  output logic                       core_reset,
  output logic                       osc_driver_off,
  output logic                       io_hold,
  output logic                       core_sleeping,
  output logic                       core_resume,
  output logic                       prefetch_next,
  output logic                       irq_vector_go,
  output logic [12:0]                irq_vector_addr
);

  // ======================================================
  // Declarations
  localparam int OST_W = $clog2(OST_CYCLES + 1);
  localparam int WDT_W = $clog2(BASE_TICKS + 1);

  wdsc_pkg::wdsc_state_t state_r;
  wdsc_pkg::wdsc_state_t state_nxt;

  logic [7:0]       prescale_r;
  logic             gie_r;
  logic             timeout_flag_r;
  logic             powerdown_flag_r;
  logic [6:0]       presc_cnt_r;
  logic [WDT_W-1:0] watchdog_counter_r;
  logic             to_req_r;
  logic             to_seen_r;
  logic [OST_W-1:0] ost_cnt_r;
  logic             vec_pend_r;

  logic             wdt_en;
  logic             prescaler_assign_bit;
  logic [2:0]       ps;
  logic             xtal_mode;
  logic             irq_pend;
  logic             to_pulse;
  logic             master_clear_pin;
  logic             any_reset;
  logic             wdt_clear;
  logic             wdt_step;
  logic [7:0]       presc_lim;
  logic             sleep_go;
  logic             wake_now;
  logic             wake_direct;

  // ======================================================
  // Configuration decode
  // fuse gates watchdog
  assign wdt_en    = config_word[`WDSC_CFG_WATCHDOG_FUSE_ENABLE_BIT];
  assign prescaler_assign_bit       = prescale_r[`WDSC_PSA_BIT];
  assign ps        = prescale_r[`WDSC_PS_MSB:0];
  assign xtal_mode = config_word[`WDSC_CFG_FOSC_MSB:0]
                     <= `WDSC_FOSC_LAST_XTAL;

  assign irq_pend = |(irq_enable_vec & irq_flag_vec);

  // Pin is active low
  assign master_clear_pin = ~master_clear_pin_in;

  assign master_clear_pin_out = 1'b0;
  assign master_clear_pin_oe  = 1'b0;

  assign to_pulse = to_req_r & ~to_seen_r;

  assign any_reset = master_clear_pin
                     | (to_pulse & (state_r == wdsc_pkg::WDSC_RUN));

  assign sleep_go = instr.sleep
                    & (state_r == wdsc_pkg::WDSC_RUN);

  assign wake_now = (state_r == wdsc_pkg::WDSC_SLEEP)
                    & (to_pulse | irq_pend);

  assign wake_direct = sleep_go & irq_pend;

  assign wdt_clear = instr.kick | sleep_go | wake_now | any_reset;

  // ======================================================
  // Power-down sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      wdsc_pkg::WDSC_RUN: begin
        if (sleep_go && !wake_direct) begin
          state_nxt = wdsc_pkg::WDSC_SLEEP;
        end
      end
      wdsc_pkg::WDSC_SLEEP: begin
        if (wake_now && xtal_mode) begin
          state_nxt = wdsc_pkg::WDSC_OST;
        end else if (wake_now) begin
          state_nxt = wdsc_pkg::WDSC_RUN;
        end
      end
      wdsc_pkg::WDSC_OST: begin
        if (ost_cnt_r == OST_W'(OST_CYCLES - 1)) begin
          state_nxt = wdsc_pkg::WDSC_RUN;
        end
      end
      default: begin
        state_nxt = wdsc_pkg::WDSC_RUN;
      end
    endcase
    if (master_clear_pin) begin
      state_nxt = wdsc_pkg::WDSC_RUN;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= wdsc_pkg::WDSC_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ======================================================
  // Oscillator start-up counter
  // 1024 periods
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ost_cnt_r <= '0;
    end else if (state_r != wdsc_pkg::WDSC_OST) begin
      ost_cnt_r <= '0;
    end else begin
      ost_cnt_r <= ost_cnt_r + OST_W'(1);
    end
  end

  // ======================================================
  // Prescaler and watchdog counter
  // ratio 1:1 to 1:128
  assign presc_lim = prescaler_assign_bit ? (8'h01 << ps) : 8'h01;
  // At-or-above test survives a ratio lowered mid-count
  assign wdt_step  = rc_osc_tick
                     & ({1'b0, presc_cnt_r} >= presc_lim - 8'h01);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      presc_cnt_r <= '0;
    end else if (wdt_clear || !wdt_en) begin
      presc_cnt_r <= '0;
    end else if (wdt_step) begin
      presc_cnt_r <= '0;
    end else if (rc_osc_tick) begin
      presc_cnt_r <= presc_cnt_r + 7'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      watchdog_counter_r <= '0;
    end else if (wdt_clear || !wdt_en) begin
      watchdog_counter_r <= '0;
    end else if (wdt_step
                 && watchdog_counter_r == WDT_W'(BASE_TICKS - 1)) begin
      watchdog_counter_r <= '0;
    end else if (wdt_step) begin
      watchdog_counter_r <= watchdog_counter_r + WDT_W'(1);
    end
  end

  // ======================================================
  // Time-out hand-off
  // level held until consumed
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      to_req_r <= 1'b0;
    end else if (wdt_en && wdt_step
                 && watchdog_counter_r == WDT_W'(BASE_TICKS - 1)) begin
      to_req_r <= 1'b1;
    end else if (wdt_clear) begin
      to_req_r <= 1'b0;
    end
  end

  // Seen marker stops a second pulse
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      to_seen_r <= 1'b0;
    end else if (!to_req_r) begin
      to_seen_r <= 1'b0;
    end else begin
      to_seen_r <= 1'b1;
    end
  end

  // ======================================================
  // Status flags
  // time-out clears timeout flag
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      timeout_flag_r <= 1'b1;
    end else if (to_pulse) begin
      timeout_flag_r <= 1'b0;
    end else if (instr.kick || sleep_go) begin
      timeout_flag_r <= 1'b1;
    end
  end

  // set at power-up, cleared by sleep
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      powerdown_flag_r <= 1'b1;
    end else if (sleep_go) begin
      powerdown_flag_r <= 1'b0;
    end else if (instr.kick) begin
      powerdown_flag_r <= 1'b1;
    end
  end

  // ======================================================
  // Software registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prescale_r <= `WDSC_PRESCALE_RST;
    end else if (any_reset) begin
      prescale_r <= `WDSC_PRESCALE_RST;
    end else if (bus_req.wr
                 && bus_req.addr == `WDSC_PRESCALE_ADDR) begin
      prescale_r <= bus_req.wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gie_r <= 1'b0;
    end else if (any_reset) begin
      gie_r <= 1'b0;
    end else if (irq_vector_go) begin
      gie_r <= 1'b0;
    end else if (bus_req.wr
                 && bus_req.addr == `WDSC_IRQCTL_ADDR) begin
      gie_r <= bus_req.wdata[`WDSC_GIE_BIT];
    end
  end

  // Read data valid one cycle after strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_rdata <= 8'h00;
    end else if (!bus_req.rd) begin
      bus_rdata <= 8'h00;
    end else begin
      case (bus_req.addr)
        `WDSC_PRESCALE_ADDR: begin
          bus_rdata <= prescale_r;
        end
        `WDSC_CONFIG_ADDR: begin
          bus_rdata <= config_word;
        end
        `WDSC_IRQCTL_ADDR: begin
          bus_rdata <= {gie_r, 7'h00};
        end
        `WDSC_STATUS_ADDR: begin
          bus_rdata <= {3'h0, timeout_flag_r,
                        powerdown_flag_r, 3'h0};
        end
        default: begin
          bus_rdata <= 8'h00;
        end
      endcase
    end
  end

  // ======================================================
  // Core control outputs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      core_reset <= 1'b0;
    end else begin
      core_reset <= any_reset;
    end
  end

  // osc off in sleep only, I/O held in sleep and start-up wait
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      osc_driver_off <= 1'b0;
      io_hold        <= 1'b0;
      core_sleeping  <= 1'b0;
    end else begin
      osc_driver_off <= state_nxt == wdsc_pkg::WDSC_SLEEP;
      io_hold        <= state_nxt != wdsc_pkg::WDSC_RUN;
      core_sleeping  <= state_nxt != wdsc_pkg::WDSC_RUN;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prefetch_next <= 1'b0;
    end else begin
      prefetch_next <= sleep_go;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      core_resume <= 1'b0;
    end else begin
      core_resume <= !master_clear_pin
                     && state_r != wdsc_pkg::WDSC_RUN
                     && state_nxt == wdsc_pkg::WDSC_RUN
                     || wake_direct && !master_clear_pin;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      vec_pend_r <= 1'b0;
    end else if (any_reset) begin
      vec_pend_r <= 1'b0;
    end else if (core_resume && gie_r && irq_pend) begin
      vec_pend_r <= 1'b1;
    end else if (vec_pend_r) begin
      vec_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_vector_go   <= 1'b0;
      irq_vector_addr <= 13'h0000;
    end else begin
      irq_vector_go   <= vec_pend_r && !any_reset;
      irq_vector_addr <= `WDSC_IRQ_VECTOR;
    end
  end

endmodule

// ### dv/wdsc_assertions.sv
`timescale 1ns/10ps
// ==========
// Checker
module wdsc_chk #(
  parameter int NUM_IRQ = 7
) (
  // Clock and reset
  input wire logic                  clk_sys,
  input wire logic                  rst,
  // Inputs seen
  input wire logic [7:0]            config_word,
  input wire wdsc_pkg::wdsc_instr_t instr,
  input wire logic [NUM_IRQ-1:0]    irq_enable_vec,
  input wire logic [NUM_IRQ-1:0]    irq_flag_vec,
  input wire logic                  master_clear_pin_in,
  // Outputs seen
  input wire logic                  master_clear_pin_oe,
  input wire logic                  core_reset,
  input wire logic                  osc_driver_off,
  input wire logic                  io_hold,
  input wire logic                  core_sleeping,
  input wire logic                  core_resume,
  input wire logic                  prefetch_next,
  input wire logic                  irq_vector_go,
  input wire logic [12:0]           irq_vector_addr
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire pend = |(irq_enable_vec & irq_flag_vec);
  wire xtal = config_word[2:0] <= 3'h2;

  sequence s_sleep_taken;
    instr.sleep && !core_sleeping && !pend && master_clear_pin_in && !core_reset;
  endsequence
  sequence s_asleep;
    ##1 (prefetch_next && osc_driver_off && io_hold);
  endsequence
  property p_sleep_entry;
    s_sleep_taken |-> s_asleep;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep entry outputs missing");
  property p_no_pin_drive;
    !master_clear_pin_oe;
  endproperty
  a_no_pin_drive: assert property (p_no_pin_drive)
    else $error("master clear pin driven");
  property p_master_clear_pin_reset;
    !master_clear_pin_in |=> core_reset;
  endproperty
  a_master_clear_pin_reset: assert property (p_master_clear_pin_reset)
    else $error("pin low gave no reset");
  property p_wdt_pulse;
    core_reset && master_clear_pin_in && $past(master_clear_pin_in) |=> !core_reset;
  endproperty
  a_wdt_pulse: assert property (p_wdt_pulse)
    else $error("watchdog reset not one cycle");
  property p_osc_sleep;
    osc_driver_off |-> io_hold && core_sleeping;
  endproperty
  a_osc_sleep: assert property (p_osc_sleep)
    else $error("osc off outside sleep");
  property p_irq_wake;
    core_sleeping && osc_driver_off && pend && master_clear_pin_in && !xtal |=> core_resume;
  endproperty
  a_irq_wake: assert property (p_irq_wake)
    else $error("enabled irq did not wake");
  property p_vector;
    irq_vector_go |-> $past(core_resume, 2) && irq_vector_addr == 13'h0004;
  endproperty
  a_vector: assert property (p_vector)
    else $error("vector out of place");
  property p_resume_no_reset;
    core_resume |-> !core_reset;
  endproperty
  a_resume_no_reset: assert property (p_resume_no_reset)
    else $error("wake came with reset");
  property p_xtal_wait;
    $fell(osc_driver_off) && xtal && master_clear_pin_in |-> !core_resume [*4];
  endproperty
  a_xtal_wait: assert property (p_xtal_wait)
    else $error("start-up wait skipped");
endmodule

bind wdsc_top wdsc_chk #(.NUM_IRQ(NUM_IRQ)) u_chk (
  .clk_sys             (clk_sys),
  .rst                 (rst),
  .config_word         (config_word),
  .instr               (instr),
  .irq_enable_vec      (irq_enable_vec),
  .irq_flag_vec        (irq_flag_vec),
  .master_clear_pin_in (master_clear_pin_in),
  .master_clear_pin_oe (master_clear_pin_oe),
  .core_reset          (core_reset),
  .osc_driver_off      (osc_driver_off),
  .io_hold             (io_hold),
  .core_sleeping       (core_sleeping),
  .core_resume         (core_resume),
  .prefetch_next       (prefetch_next),
  .irq_vector_go       (irq_vector_go),
  .irq_vector_addr     (irq_vector_addr)
);

// ### dv/wdsc_tb_top.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
// ==========
// Bench
module wdsc_tb_top;
  logic                  clk_sys = 1'b0;
  logic                  rst = 1'b1;
  wdsc_pkg::wdsc_bus_req_t bus_req = '0;
  wdsc_pkg::wdsc_instr_t instr = '0;
  logic [7:0]            bus_rdata;
  logic [7:0]            config_word = 8'h0F;
  logic                  rc_osc_tick = 1'b0;
  logic [6:0]            irq_enable_vec = 7'h00;
  logic [6:0]            irq_flag_vec = 7'h00;
  logic                  master_clear_pin_in = 1'b1;
  logic                  master_clear_pin_out, master_clear_pin_oe, core_reset;
  logic                  osc_driver_off, io_hold, core_sleeping, core_resume;
  logic                  prefetch_next, irq_vector_go;
  logic [12:0]           irq_vector_addr;
  int                    num_errors = 0;
  int                    n_tests = 0;
  int                    cyc = 0;
  int                    nrst = 0;
  int                    n, m;

  // Short counts keep the run brief
  wdsc_top #(.BASE_TICKS(4), .OST_CYCLES(8)) u_dut (
    .clk_sys              (clk_sys),
    .rst                  (rst),
    .bus_req              (bus_req),
    .bus_rdata            (bus_rdata),
    .config_word          (config_word),
    .rc_osc_tick          (rc_osc_tick),
    .instr                (instr),
    .irq_enable_vec       (irq_enable_vec),
    .irq_flag_vec         (irq_flag_vec),
    .master_clear_pin_in  (master_clear_pin_in),
    .master_clear_pin_out (master_clear_pin_out),
    .master_clear_pin_oe  (master_clear_pin_oe),
    .core_reset           (core_reset),
    .osc_driver_off       (osc_driver_off),
    .io_hold              (io_hold),
    .core_sleeping        (core_sleeping),
    .core_resume          (core_resume),
    .prefetch_next        (prefetch_next),
    .irq_vector_go        (irq_vector_go),
    .irq_vector_addr      (irq_vector_addr)
  );

  always #12.5 clk_sys = ~clk_sys;

  task final_report;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (core_reset === 1'b1)
      nrst++;
    if (cyc > 6000) begin
      num_errors++;
      final_report;
    end
  end

  // ==========
  // Access tasks
  task wr(input logic [13:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_req.wr <= 1'b1;
    bus_req.addr <= a;
    bus_req.wdata <= d;
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask

  task rdc(input logic [13:0] a, input logic [7:0] e, input string nm);
    @(posedge clk_sys);
    bus_req.rd <= 1'b1;
    bus_req.addr <= a;
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    @(negedge clk_sys);
    `CHK(nm, e, bus_rdata)
    @(posedge clk_sys);
  endtask

  task ins(input logic k);
    @(posedge clk_sys);
    instr <= '{kick: k, sleep: !k};
    @(posedge clk_sys);
    instr <= '0;
  endtask

  // Cycles until reset (0), resume (1) or vector (2)
  task wt(input int w, output int c);
    c = 0;
    do begin
      @(negedge clk_sys);
      c++;
    end while ((w == 0 ? core_reset : w == 1 ? core_resume : irq_vector_go) !== 1'b1 && c < 2000);
    @(posedge clk_sys);
  endtask

  task ticks(input logic on);
    @(posedge clk_sys);
    rc_osc_tick <= on;
  endtask

  // ==========
  // Tests
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rdc(14'h0081, 8'hFF, "prescale rst");
    rdc(14'h0003, 8'h18, "status rst");
    rdc(14'h000B, 8'h00, "gie rst");
    wr(14'h2007, 8'h00);
    rdc(14'h2007, 8'h0F, "config ro");
    rdc(14'h0005, 8'h00, "unmapped");
    wr(14'h0081, 8'h5A);
    rdc(14'h0081, 8'h5A, "prescale rw");
    wr(14'h000B, 8'h80);
    for (int p = 0; p < 8; p++) begin
      ins(1'b1);
      wr(14'h0081, p == 0 ? 8'h00 : 8'(8 + p));
      ticks(1'b1);
      wt(0, n);
      ticks(1'b0);
      `CHK("wdt period", 1'b1, n >= (4 << p) && n <= (4 << p) + 4)
    end
    rdc(14'h0003, 8'h08, "status to");
    `CHK("one reset per time-out", 8, nrst)
    rdc(14'h000B, 8'h00, "gie after reset");
    rdc(14'h0081, 8'hFF, "prescale after reset");
    wr(14'h0081, 8'h00);
    m = nrst;
    ticks(1'b1);
    repeat (10) ins(1'b1);
    `CHK("kick holds off", m, nrst)
    config_word <= 8'h07;
    repeat (40) @(posedge clk_sys);
    `CHK("fuse off", m, nrst)
    ticks(1'b0);
    config_word <= 8'h0F;
    wr(14'h000B, 8'h80);
    ins(1'b0);
    @(negedge clk_sys);
    `CHK("prefetch", 1'b1, prefetch_next)
    `CHK("osc off", 1'b1, osc_driver_off & io_hold)
    rdc(14'h0003, 8'h10, "status sleep");
    irq_flag_vec <= 7'h01;
    repeat (10) @(posedge clk_sys);
    `CHK("masked irq", 1'b1, core_sleeping)
    irq_enable_vec <= 7'h01;
    wt(1, n);
    `CHK("irq wake", 1'b1, n <= 3)
    wt(2, n);
    `CHK("vector delay", 2, n)
    `CHK("vector addr", 13'h0004, irq_vector_addr)
    ins(1'b0);
    @(negedge clk_sys);
    `CHK("direct wake", 1'b1, core_resume)
    `CHK("direct stays awake", 1'b0, core_sleeping)
    rdc(14'h0003, 8'h10, "status direct");
    irq_flag_vec <= 7'h00;
    config_word <= 8'h0A;
    ins(1'b0);
    repeat (3) @(posedge clk_sys);
    irq_flag_vec <= 7'h01;
    wt(1, n);
    `CHK("osc start wait", 1'b1, n >= 8 && n <= 12)
    irq_flag_vec <= 7'h00;
    config_word <= 8'h0F;
    m = nrst;
    ins(1'b0);
    ticks(1'b1);
    wt(1, n);
    ticks(1'b0);
    `CHK("wdt wake", 1'b1, n <= 10)
    `CHK("no reset", m, nrst)
    rdc(14'h0003, 8'h00, "status wake");
    ins(1'b0);
    @(posedge clk_sys);
    master_clear_pin_in <= 1'b0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK("master_clear_pin reset", 1'b1, core_reset)
    `CHK("pin oe", 1'b0, master_clear_pin_oe)
    `CHK("pin out", 1'b0, master_clear_pin_out)
    @(posedge clk_sys);
    master_clear_pin_in <= 1'b1;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK("awake", 1'b0, core_sleeping)
    `CHK("master_clear_pin released", 1'b0, core_reset)
    final_report;
  end
endmodule
